// ### prx_pkg.sv
package prx_pkg;

    // ------------------------------------------------------------------
    // Lane and data path geometry
    // ------------------------------------------------------------------
    localparam int LANES = 4;
    localparam int BYTE_W = 8;
    localparam int WORD_W = LANES * BYTE_W;
    localparam int FIFO_DEPTH = 8;
    localparam int SKEW_DEPTH = 8;
    localparam int SKEW_CNT_W = 4;
    localparam logic [SKEW_CNT_W-1:0] MAX_SKEW = 4'h7;

    // ------------------------------------------------------------------
    // Training set screening
    // ------------------------------------------------------------------
    localparam int TS1_S7_RSVD_BIT = 6;
    localparam logic [7:0] TS1_S7_RSVD_MASK = 8'h40;

    // ------------------------------------------------------------------
    // Recovery timing after a failed alignment
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 200;
    localparam int RECOV_TIME_US = 200;
    localparam int RECOV_CYCLES = RECOV_TIME_US * CLK_MHZ;
    localparam int RECOV_CNT_W = 16;

    // ------------------------------------------------------------------
    // Non-posted request path
    // ------------------------------------------------------------------
    localparam int TAG_W = 8;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam logic [TAG_W-1:0] TAG_RESET = 8'h00;

    // Receive alignment states
    typedef enum logic [4:0] {
        AL_L0 = 5'b00001,
        AL_L0S = 5'b00010,
        AL_FTS = 5'b00100,
        AL_SKP = 5'b01000,
        AL_RECOV = 5'b10000
    } prx_align_e;

    // Non-posted request states
    typedef enum logic [2:0] {
        NP_IDLE = 3'b001,
        NP_ISSUE = 3'b010,
        NP_WAIT = 3'b100
    } prx_np_e;

    // One received symbol slice across all lanes
    typedef struct packed {
        logic [LANES-1:0][BYTE_W-1:0] data;
        logic valid;
        logic fts;
        logic [LANES-1:0] skp;
    } prx_lanes_s;

    // Completion returning from the link
    typedef struct packed {
        logic valid;
        logic [TAG_W-1:0] tag;
        logic [DATA_W-1:0] data;
    } prx_cpl_s;

endpackage

// ### prx_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module prx_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ff;
    logic [AW-1:0] rd_ff;
    logic [AW:0] cnt_ff;
    logic full_ff;
    logic empty_ff;
    logic push;
    logic pop;
    logic [AW:0] nxt_cnt;

    // Handshakes on both sides, flags kept in flops
    assign push = in_valid & ~full_ff;
    assign pop = out_ready & ~empty_ff;
    assign nxt_cnt = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    assign in_ready = ~full_ff;
    assign out_valid = ~empty_ff;
    assign out_data = mem[rd_ff];

    // Storage array, written only on an accepted push
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ff] <= in_data;
        end
    end

    // Pointers, count and flags
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
            full_ff <= 1'b0;
            empty_ff <= 1'b1;
        end else begin
            if (push) begin
                wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
            end
            if (pop) begin
                rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
            end
            cnt_ff <= nxt_cnt;
            full_ff <= (nxt_cnt == (AW+1)'(DEPTH));
            empty_ff <= (nxt_cnt == '0);
        end
    end

endmodule

`default_nettype wire

// ### prx_rx_core.sv
// Function
// - Reserved bits of TS1/TS2 carry no weight in validity decisions.
// - Gen3/Gen4 TS1 never rejected for reserved symbol 7 bit 6.
// - On L0s exit expect fast training sets first, then a skip set.
// - Skip set on L0s exit aligns lanes before data is forwarded.
// - Alignment failure pulses the correctable error output.
// - Alignment failure enters recovery and returns to L0, no link down.
// - Recovery after a failed alignment delays L0s exit about 200us.
// - Completions accepted only when tag equals the recorded request tag.
// - After link down, next non-posted request records its own tag.
`timescale 1ns/1ps
`default_nettype none

module prx_rx_core
    import prx_pkg::*;
#(
    parameter int RECOV_CYC = RECOV_CYCLES
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic gen34_rate,
    input wire logic ts1_valid,
    input wire logic [7:0] ts1_sym6,
    input wire logic [7:0] ts1_sym7,
    output logic ts1_accept,
    output logic [7:0] ts1_sym6_out,
    output logic [7:0] ts1_sym7_out,
    input wire logic rx_enter_l0s,
    input wire prx_lanes_s rx_lanes,
    output logic rx_in_l0,
    output logic rx_in_recovery,
    output logic err_pulse_int,
    output logic rx_stall,
    output logic rx_word_valid,
    output logic [WORD_W-1:0] rx_word,
    input wire logic rx_word_ready,
    input wire logic link_up,
    input wire logic link_down,
    input wire logic tb_rd_valid,
    input wire logic [ADDR_W-1:0] tb_rd_addr,
    output logic tb_rd_ready,
    output logic tb_rd_done,
    output logic [DATA_W-1:0] tb_rd_data,
    output logic np_req_valid,
    output logic [TAG_W-1:0] np_req_tag,
    output logic [ADDR_W-1:0] np_req_addr,
    input wire prx_cpl_s cpl_in
);

    // ------------------------------------------------------------------
    // State of the whole block
    // ------------------------------------------------------------------
    typedef struct packed {
        logic ts1_accept;
        logic [7:0] ts1_sym6;
        logic [7:0] ts1_sym7;
        prx_align_e al;
        logic [SKEW_CNT_W-1:0] skew_cnt;
        logic [LANES-1:0] arrived;
        logic [LANES-1:0][SKEW_CNT_W-1:0] arr_at;
        logic [LANES-1:0][SKEW_CNT_W-1:0] delay;
        logic [LANES-1:0][SKEW_DEPTH-1:0][BYTE_W-1:0] hist;
        logic [RECOV_CNT_W-1:0] recov_cnt;
        logic err_pulse;
        logic push;
        logic [WORD_W-1:0] push_word;
        prx_np_e np;
        logic [TAG_W-1:0] next_tag;
        logic [TAG_W-1:0] rec_tag;
        logic [ADDR_W-1:0] rd_addr;
        logic tb_ready;
        logic tb_done;
        logic [DATA_W-1:0] tb_data;
        logic np_valid;
        logic [TAG_W-1:0] np_tag;
        logic [ADDR_W-1:0] np_addr;
    } prx_state_s;

    localparam logic [RECOV_CNT_W-1:0] RECOV_LAST =
        RECOV_CNT_W'(RECOV_CYC - 1);

    prx_state_s st_ff;
    prx_state_s nxt_st;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [WORD_W-1:0] fifo_out_data;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        logic [SKEW_CNT_W-1:0] now;
        logic [LANES-1:0] all_arr;
        logic [WORD_W-1:0] word;
        now = st_ff.skew_cnt + 1'b1;
        all_arr = st_ff.arrived | rx_lanes.skp;
        word = '0;
        nxt_st = st_ff;
        nxt_st.err_pulse = 1'b0;
        nxt_st.push = 1'b0;
        nxt_st.tb_ready = 1'b0;
        nxt_st.tb_done = 1'b0;
        nxt_st.np_valid = 1'b0;

        // TS1 screening: reserved bit masked before forwarding, the set
        // is taken on its presence alone at every rate
        nxt_st.ts1_accept = ts1_valid;
        if (ts1_valid) begin
            nxt_st.ts1_sym6 = ts1_sym6;
            nxt_st.ts1_sym7 = ts1_sym7 & ~TS1_S7_RSVD_MASK;
        end

        // Per-lane history for deskew; the byte for a lane with delay d
        // is the one that arrived d cycles ago
        for (int i = 0; i < LANES; i++) begin
            nxt_st.hist[i] = {st_ff.hist[i][SKEW_DEPTH-2:0],
                              rx_lanes.data[i]};
            if (st_ff.delay[i] == '0) begin
                word[i*BYTE_W +: BYTE_W] = rx_lanes.data[i];
            end else begin
                word[i*BYTE_W +: BYTE_W] =
                    st_ff.hist[i][st_ff.delay[i][2:0] - 3'h1];
            end
        end

        // Receive alignment sequence
        case (st_ff.al)
            AL_L0: begin
                if (rx_enter_l0s) begin
                    nxt_st.al = AL_L0S;
                end else if (rx_lanes.valid && fifo_in_ready) begin
                    nxt_st.push = 1'b1;
                    nxt_st.push_word = word;
                end
            end
            AL_L0S: begin
                // A skip set before any fast training set is ignored
                if (rx_lanes.fts) begin
                    nxt_st.al = AL_FTS;
                end
            end
            AL_FTS: begin
                if (rx_lanes.skp != '0) begin
                    nxt_st.arrived = rx_lanes.skp;
                    nxt_st.skew_cnt = '0;
                    for (int i = 0; i < LANES; i++) begin
                        nxt_st.arr_at[i] = '0;
                        nxt_st.delay[i] = '0;
                    end
                    nxt_st.al = (rx_lanes.skp == '1) ? AL_L0 : AL_SKP;
                end
            end
            AL_SKP: begin
                nxt_st.skew_cnt = now;
                for (int i = 0; i < LANES; i++) begin
                    if (rx_lanes.skp[i] && !st_ff.arrived[i]) begin
                        nxt_st.arr_at[i] = now;
                    end
                end
                nxt_st.arrived = all_arr;
                if (all_arr == '1) begin
                    // Last lane sets the reference; any arrival slot works
                    for (int i = 0; i < LANES; i++) begin
                        nxt_st.delay[i] = rx_lanes.skp[i] &&
                            !st_ff.arrived[i] ? '0 :
                            now - st_ff.arr_at[i];
                    end
                    nxt_st.al = AL_L0;
                end else if (now >= MAX_SKEW) begin
                    nxt_st.err_pulse = 1'b1;
                    nxt_st.recov_cnt = '0;
                    nxt_st.al = AL_RECOV;
                end
            end
            AL_RECOV: begin
                // Retrain to L0 without touching link state
                nxt_st.recov_cnt = st_ff.recov_cnt + 1'b1;
                if (st_ff.recov_cnt == RECOV_LAST) begin
                    for (int i = 0; i < LANES; i++) begin
                        nxt_st.delay[i] = '0;
                    end
                    nxt_st.al = AL_L0;
                end
            end
            default: begin
                nxt_st.al = AL_L0;
            end
        endcase

        // Non-posted read path from the internal target bus
        case (st_ff.np)
            NP_IDLE: begin
                if (tb_rd_valid) begin
                    nxt_st.tb_ready = 1'b1;
                    nxt_st.rd_addr = tb_rd_addr;
                    nxt_st.np = NP_ISSUE;
                end
            end
            NP_ISSUE: begin
                // Issue and tag record come from one value in one cycle,
                // and never in a cycle that carries link down
                if (link_up && !link_down) begin
                    nxt_st.np_valid = 1'b1;
                    nxt_st.np_tag = st_ff.next_tag;
                    nxt_st.np_addr = st_ff.rd_addr;
                    nxt_st.rec_tag = st_ff.next_tag;
                    nxt_st.next_tag = st_ff.next_tag + 1'b1;
                    nxt_st.np = NP_WAIT;
                end
            end
            NP_WAIT: begin
                if (link_down) begin
                    nxt_st.np = NP_ISSUE;
                end else if (cpl_in.valid &&
                             cpl_in.tag == st_ff.rec_tag) begin
                    nxt_st.tb_done = 1'b1;
                    nxt_st.tb_data = cpl_in.data;
                    nxt_st.np = NP_IDLE;
                end
            end
            default: begin
                nxt_st.np = NP_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '0;
            st_ff.al <= AL_L0;
            st_ff.np <= NP_IDLE;
            st_ff.next_tag <= TAG_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // Aligned data buffer
    // ------------------------------------------------------------------
    prx_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .in_valid(st_ff.push),
        .in_data(st_ff.push_word),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_out_valid),
        .out_data(fifo_out_data),
        .out_ready(rx_word_ready)
    );

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign ts1_accept = st_ff.ts1_accept;
    assign ts1_sym6_out = st_ff.ts1_sym6;
    assign ts1_sym7_out = st_ff.ts1_sym7;
    assign rx_in_l0 = (st_ff.al == AL_L0);
    assign rx_in_recovery = (st_ff.al == AL_RECOV);
    assign err_pulse_int = st_ff.err_pulse;
    assign rx_stall = ~fifo_in_ready; // Full flag
    assign rx_word_valid = fifo_out_valid;
    assign rx_word = fifo_out_data;
    assign tb_rd_ready = st_ff.tb_ready;
    assign tb_rd_done = st_ff.tb_done;
    assign tb_rd_data = st_ff.tb_data;
    assign np_req_valid = st_ff.np_valid;
    assign np_req_tag = st_ff.np_tag;
    assign np_req_addr = st_ff.np_addr;

endmodule

`default_nettype wire

// ### prx_rx_core_props.sv
`timescale 1ns/1ps
`default_nettype none

module prx_rx_core_props
    import prx_pkg::*;
#(
    parameter int RECOV_CYC = RECOV_CYCLES
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic ts1_valid,
    input wire logic [7:0] ts1_sym6,
    input wire logic [7:0] ts1_sym7,
    input wire logic ts1_accept,
    input wire logic [7:0] ts1_sym6_out,
    input wire logic [7:0] ts1_sym7_out,
    input wire logic rx_enter_l0s,
    input wire logic rx_in_l0,
    input wire logic rx_in_recovery,
    input wire logic err_pulse_int,
    input wire logic tb_rd_done,
    input wire logic link_down,
    input wire logic np_req_valid,
    input wire logic [TAG_W-1:0] np_req_tag,
    input wire prx_cpl_s cpl_in
);
    logic [15:0] rec_cnt_ff;
    logic [TAG_W-1:0] tag_ff;
    logic seen_ff;
    logic wait_ff;

    // Track recovery length, last issued tag and an open read
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rec_cnt_ff <= 16'h0;
            tag_ff <= '0;
            seen_ff <= 1'b0;
            wait_ff <= 1'b0;
        end else begin
            rec_cnt_ff <= rx_in_recovery ? rec_cnt_ff + 16'h1 : 16'h0;
            tag_ff <= np_req_valid ? np_req_tag : tag_ff;
            seen_ff <= seen_ff | np_req_valid;
            wait_ff <= np_req_valid | (wait_ff & ~tb_rd_done);
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    // Steps of the watched behaviours
    sequence s_ts1; ts1_valid; endsequence
    sequence s_leave; rx_in_l0 && rx_enter_l0s; endsequence
    // Link down in the same cycle sends the read back to reissue
    sequence s_hit;
        wait_ff && !link_down && cpl_in.valid && cpl_in.tag == tag_ff;
    endsequence
    sequence s_miss; cpl_in.valid && cpl_in.tag != tag_ff; endsequence

    ts1_take_a: assert property (s_ts1 |=> ts1_accept)
        else $error("set not taken");
    ts1_mask_a: assert property (s_ts1 |=> ts1_sym7_out[6] == 1'b0
        && ts1_sym7_out[5:0] == $past(ts1_sym7[5:0])
        && ts1_sym6_out == $past(ts1_sym6)) else $error("symbols wrong");
    l0s_leave_a: assert property (s_leave |=> !rx_in_l0)
        else $error("stayed in L0");
    err_state_a: assert property (err_pulse_int |-> rx_in_recovery
        && !rx_in_l0) else $error("error without recovery");
    err_pulse_a: assert property (err_pulse_int |=> !err_pulse_int [*8])
        else $error("error pulse too long");
    state_excl_a: assert property (!(rx_in_l0 && rx_in_recovery))
        else $error("two states at once");
    recov_len_a: assert property ($fell(rx_in_recovery) |-> rx_in_l0
        && rec_cnt_ff == 16'(RECOV_CYC)) else $error("recovery length");
    tag_step_a: assert property (np_req_valid && seen_ff |->
        np_req_tag == tag_ff + 8'h01) else $error("tag not next");
    cpl_hit_a: assert property (s_hit |=> tb_rd_done)
        else $error("read not finished");
    cpl_miss_a: assert property (s_miss |=> !tb_rd_done)
        else $error("wrong tag accepted");
endmodule

bind prx_rx_core prx_rx_core_props #(.RECOV_CYC(RECOV_CYC)) u_props (
    .clk_sys, .reset_n, .ts1_valid, .ts1_sym6, .ts1_sym7, .ts1_accept,
    .ts1_sym6_out, .ts1_sym7_out, .rx_enter_l0s, .rx_in_l0,
    .rx_in_recovery, .err_pulse_int, .tb_rd_done, .link_down, .np_req_valid,
    .np_req_tag, .cpl_in);

`default_nettype wire

// ### prx_link_model.sv
`timescale 1ns/1ps
`default_nettype none

module prx_link_model
    import prx_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic np_req_valid,
    input wire logic [TAG_W-1:0] np_req_tag,
    input wire logic [ADDR_W-1:0] np_req_addr,
    input wire logic link_down,
    input wire logic [3:0] delay,
    input wire logic bad_first,
    output prx_cpl_s cpl_in
);
    logic busy_ff;
    logic bad_ff;
    logic [3:0] cnt_ff;
    logic [TAG_W-1:0] tag_ff;
    logic [DATA_W-1:0] dat_ff;

    // Answer a request after a delay, optionally with a wrong tag first
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            busy_ff <= 1'b0;
            bad_ff <= 1'b0;
            cnt_ff <= 4'h0;
            tag_ff <= '0;
            dat_ff <= '0;
            cpl_in <= '0;
        end else begin
            cpl_in.valid <= 1'b0;
            cpl_in.tag <= ~cpl_in.tag;
            cpl_in.data <= ~cpl_in.data;
            // Link loss wins over a request seen in the same cycle
            if (link_down) begin
                busy_ff <= 1'b0; // Link loss drops the request
            end else if (np_req_valid) begin
                busy_ff <= 1'b1;
                bad_ff <= bad_first;
                cnt_ff <= delay;
                tag_ff <= np_req_tag;
                dat_ff <= np_req_addr ^ 32'h5a5aa5a5;
            end else if (busy_ff && cnt_ff != 4'h0) begin
                cnt_ff <= cnt_ff - 4'h1;
            end else if (busy_ff) begin
                cpl_in.valid <= 1'b1;
                cpl_in.tag <= bad_ff ? tag_ff + 8'h01 : tag_ff;
                cpl_in.data <= dat_ff;
                busy_ff <= bad_ff;
                bad_ff <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

// ### pcie_rx_os_deskew_tag_check_bench.sv
`timescale 1ns/1ps
`default_nettype none

module pcie_rx_os_deskew_tag_check_bench import prx_pkg::*;;
    localparam int RECOV = 20;
    logic clk_sys, reset_n, gen34_rate, ts1_valid, ts1_accept, rx_enter_l0s;
    logic [7:0] ts1_sym6, ts1_sym7, ts1_sym6_out, ts1_sym7_out, s6, s7, prev;
    logic rx_in_l0, rx_in_recovery, err_pulse_int, rx_stall, rx_word_valid;
    logic rx_word_ready, link_up, link_down, tb_rd_valid, tb_rd_ready;
    logic tb_rd_done, np_req_valid, bad_first, have_tag, resync;
    logic [WORD_W-1:0] rx_word;
    logic [ADDR_W-1:0] tb_rd_addr, np_req_addr;
    logic [DATA_W-1:0] tb_rd_data;
    logic [TAG_W-1:0] np_req_tag, last_tag;
    logic [3:0] delay;
    logic [31:0] seed, r;
    prx_lanes_s rx_lanes;
    prx_cpl_s cpl_in;
    int bad_count, tests_run, cyc, n, k;
    int arr[LANES];

    prx_rx_core #(.RECOV_CYC(RECOV)) dut (.clk_sys, .reset_n, .gen34_rate,
        .ts1_valid, .ts1_sym6, .ts1_sym7, .ts1_accept, .ts1_sym6_out,
        .ts1_sym7_out, .rx_enter_l0s, .rx_lanes, .rx_in_l0, .rx_in_recovery,
        .err_pulse_int, .rx_stall, .rx_word_valid, .rx_word, .rx_word_ready,
        .link_up, .link_down, .tb_rd_valid, .tb_rd_addr, .tb_rd_ready,
        .tb_rd_done, .tb_rd_data, .np_req_valid, .np_req_tag, .np_req_addr,
        .cpl_in);
    prx_link_model link (.clk_sys, .reset_n, .np_req_valid, .np_req_tag,
        .np_req_addr, .link_down, .delay, .bad_first, .cpl_in);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("mismatches %0d, checks %0d", bad_count, tests_run);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic wait_hi(ref logic sig, input int lim);
        n = 0;
        while (sig !== 1'b1) begin
            @(posedge clk_sys);
            n++;
            if (n > lim) begin
                bad_count++;
                $display("wrong value at %0t: wait ran out", $time);
                print_verdict();
            end
        end
    endtask

    task automatic align(input logic fail);
        rx_enter_l0s <= 1'b1;
        @(posedge clk_sys);
        rx_enter_l0s <= 1'b0;
        rx_lanes.fts <= 1'b1;
        @(posedge clk_sys);
        rx_lanes.fts <= 1'b0;
        for (int i = 0; i < LANES; i++) begin
            r = rnd();
            arr[i] = cyc + 3 + (fail ? ((i == 3) ? 8 : 0) : int'(r % 7));
        end
        if (fail) begin
            wait_hi(err_pulse_int, 40);
            chk(rx_in_recovery, 1'b1);
            arr[3] = arr[0]; // Retraining leaves the lanes in step
            for (k = 0; rx_in_recovery === 1'b1 && k < RECOV + 9; k++) begin
                @(posedge clk_sys);
            end
            chk(k, RECOV);
        end
        wait_hi(rx_in_l0, 40);
        chk(rx_in_recovery, 1'b0);
        resync = 1'b1;
    endtask

    task automatic rd(input logic bad, input int lag);
        logic [31:0] a;
        a = rnd();
        r = rnd();
        bad_first <= bad;
        delay <= r[3:0];
        tb_rd_valid <= 1'b1;
        tb_rd_addr <= a;
        @(posedge clk_sys);
        wait_hi(tb_rd_ready, 10);
        tb_rd_valid <= 1'b0;
        if (lag != 0) begin
            repeat (lag - 1) @(posedge clk_sys);
            link_down <= 1'b1;
            @(posedge clk_sys);
            link_down <= 1'b0;
        end
        wait_hi(tb_rd_done, 200);
        chk(tb_rd_data, a ^ 32'h5a5aa5a5);
        @(posedge clk_sys);
    endtask

    // ----------------------------------------
    // Stimulus and checks
    // ----------------------------------------
    // Clock
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // Lane bytes count up from each lane's own skip set
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        for (int i = 0; i < LANES; i++) begin
            rx_lanes.data[i] <= 8'(cyc - arr[i]);
            rx_lanes.skp[i] <= (cyc == arr[i]);
        end
    end

    // Popped words are aligned and follow on without gaps
    always @(posedge clk_sys) begin
        if (reset_n && rx_word_valid === 1'b1 && rx_word_ready) begin
            chk(rx_word, {4{rx_word[7:0]}});
            if (!resync) chk(rx_word[7:0], 8'(prev + 8'h01));
            prev = rx_word[7:0];
            resync = 1'b0;
        end
    end

    // Each request carries the tag after the previous one
    always @(posedge clk_sys) begin
        if (reset_n && np_req_valid === 1'b1) begin
            if (have_tag) chk(np_req_tag, 8'(last_tag + 8'h01));
            last_tag = np_req_tag;
            have_tag = 1'b1;
        end
    end

    // Main sequence
    initial begin
        seed = 32'd81380;
        {bad_count, tests_run, cyc, have_tag, prev} = '0;
        arr = '{default: -100};
        {reset_n, gen34_rate, ts1_valid, ts1_sym6, ts1_sym7} = '0;
        {rx_enter_l0s, link_down, tb_rd_valid, tb_rd_addr} = '0;
        {delay, bad_first, rx_lanes} = '0;
        {resync, rx_word_ready, link_up} = 3'b111;
        rx_lanes.valid = 1'b1;
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            r = rnd();
            s6 = (i < 8) ? {r[7], (i[0] ? 7'h4a : 7'h45)} : r[7:0];
            s7 = (i < 8) ? {r[8], 1'b1, (i[1] ? 6'h0a : 6'h05)} : r[15:8];
            gen34_rate <= i[2];
            ts1_valid <= 1'b1;
            ts1_sym6 <= s6;
            ts1_sym7 <= s7;
            @(posedge clk_sys);
            ts1_valid <= 1'b0;
            @(posedge clk_sys);
            chk(ts1_accept, 1'b1);
            chk({ts1_sym6_out, ts1_sym7_out}, {s6, s7 & 8'hbf});
        end
        for (int i = 0; i < 6; i++) begin
            align(i == 3);
            for (int j = 0; j < 16; j++) begin
                r = rnd();
                // Sparse stalls keep the buffer short of full
                rx_word_ready <= r[0] || (j[1:0] != 2'h0);
                @(posedge clk_sys);
            end
            rx_word_ready <= 1'b1;
            repeat (6) @(posedge clk_sys);
        end
        rx_word_ready <= 1'b0;
        wait_hi(rx_stall, 30);
        rx_lanes.valid <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rx_word_ready <= 1'b1;
        for (k = 0; rx_word_valid === 1'b1 && k < 20; k++) begin
            @(posedge clk_sys);
        end
        chk(k >= FIFO_DEPTH, 1'b1);
        resync = 1'b1;
        rx_lanes.valid <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rd(i[0], int'(i[2:1]));
        end
        print_verdict();
    end
endmodule

`default_nettype wire
